/* atmd_pkg.sv */
// Package with the register map, field layout and state types of the block.
package atmd_pkg;

    // ========================================================================
    // Register indices; the byte address of a register is four times these.
    // ========================================================================
    localparam logic [7:0] IDX_PHASE_TARGET = 8'h22;
    localparam logic [7:0] IDX_RESULT_VIEW  = 8'h23;
    localparam logic [7:0] IDX_MOD_CTRL     = 8'h24;
    localparam logic [7:0] IDX_TRIM_CTRL    = 8'h30;
    localparam logic [7:0] IDX_SEG_MASK     = 8'h31;
    localparam logic [7:0] IDX_COMMAND      = 8'h32;
    localparam logic [7:0] IDX_IRQ_STATUS   = 8'h33;
    localparam logic [7:0] IDX_IRQ_CLEAR    = 8'h34;
    localparam logic [7:0] IDX_IRQ_ENABLE   = 8'h35;

    // ========================================================================
    // Reset values, field positions and writable masks.
    // ========================================================================
    localparam logic [7:0] PHASE_TARGET_RST = 8'h80;
    localparam logic [7:0] RESULT_VIEW_RST  = 8'h00;
    localparam logic [7:0] MOD_CTRL_RST     = 8'h00;
    localparam logic [7:0] TRIM_CTRL_RST    = 8'h00;
    localparam logic [7:0] SEG_MASK_RST     = 8'h00;
    localparam logic [2:0] IRQ_RST          = 3'h0;
    localparam int RES_TRIM_MSB  = 7;
    localparam int RES_TRIM_LSB  = 4;
    localparam int RES_ERR_BIT   = 3;
    localparam int MOD_SEL_BIT   = 7;
    localparam int DEPTH_MSB     = 6;
    localparam int DEPTH_LSB     = 1;
    localparam int TRIM_SEL_BIT  = 7;
    localparam int TRIM_MAN_MSB  = 6;
    localparam int TRIM_MAN_LSB  = 3;
    localparam logic [7:0] MOD_CTRL_WMASK  = 8'hFE;
    localparam logic [7:0] TRIM_CTRL_WMASK = 8'hF8;
    localparam int CMD_SET_DEFAULT = 0;
    localparam int CMD_CAL_ANT     = 1;
    localparam int CMD_CAL_MOD     = 2;
    localparam int IRQ_ANT_DONE    = 0;
    localparam int IRQ_ANT_ERR     = 1;
    localparam int IRQ_MOD_DONE    = 2;

    // ========================================================================
    // Carriers for the calibration engine results and the block state.
    // ========================================================================
    typedef struct packed {
        logic       done;
        logic       err;
        logic [3:0] trim;
    } atmd_ant_res_s;

    typedef struct packed {
        logic       done;
        logic [5:0] code;
    } atmd_mod_res_s;

    typedef struct packed {
        logic [7:0]  phase_target;
        logic [7:0]  result_view;
        logic [7:0]  mod_ctrl;
        logic [7:0]  trim_ctrl;
        logic [7:0]  seg_mask;
        logic [2:0]  irq_status;
        logic [2:0]  irq_enable;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        ant_start;
        logic        mod_start;
        logic [3:0]  trim_out;
        logic [7:0]  seg_disable;
    } atmd_state_s;

    localparam atmd_state_s ATMD_STATE_RST = '{
        phase_target: PHASE_TARGET_RST,
        result_view:  RESULT_VIEW_RST,
        mod_ctrl:     MOD_CTRL_RST,
        trim_ctrl:    TRIM_CTRL_RST,
        seg_mask:     SEG_MASK_RST,
        irq_status:   IRQ_RST,
        irq_enable:   IRQ_RST,
        default:      '0
    };

endpackage : atmd_pkg

/* atmd_regs.sv */
// Antenna tuning and modulation depth register bank behind an APB slave.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps

module atmd_regs (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire atmd_pkg::atmd_ant_res_s ant_cal_res,
    input  wire atmd_pkg::atmd_mod_res_s mod_cal_res,
    output logic                        ant_cal_start,
    output logic                        mod_cal_start,
    output logic      [7:0]             phase_target,
    output logic      [3:0]             tank_switch_pin_set_one,
    output logic      [3:0]             tank_switch_pin_set_two,
    output logic                        mod_level_source_sel,
    output logic      [5:0]             depth_code,
    output logic      [7:0]             am_segment_disable,
    output logic                        irq
);

    // ========================================================================
    // Helper functions.
    // ========================================================================
    // Decodes a word address against a register index.
    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [7:0] idx);
        reg_hit = (addr[7:2] == idx[5:0]);
    endfunction : reg_hit

    // Returns the read value of the register addressed, zero with the error bit set if unmapped.
    function automatic logic [8:0] read_mux(input logic [7:0] addr,
                                            input atmd_pkg::atmd_state_s s);
        read_mux = {1'b1, 8'h00};
        if (reg_hit(addr, atmd_pkg::IDX_PHASE_TARGET)) begin
            read_mux = {1'b0, s.phase_target};
        end else if (reg_hit(addr, atmd_pkg::IDX_RESULT_VIEW)) begin
            read_mux = {1'b0, s.result_view};
        end else if (reg_hit(addr, atmd_pkg::IDX_MOD_CTRL)) begin
            read_mux = {1'b0, s.mod_ctrl};
        end else if (reg_hit(addr, atmd_pkg::IDX_TRIM_CTRL)) begin
            read_mux = {1'b0, s.trim_ctrl};
        end else if (reg_hit(addr, atmd_pkg::IDX_SEG_MASK)) begin
            read_mux = {1'b0, s.seg_mask};
        end else if (reg_hit(addr, atmd_pkg::IDX_COMMAND)) begin
            read_mux = {1'b0, 8'h00};
        end else if (reg_hit(addr, atmd_pkg::IDX_IRQ_STATUS)) begin
            read_mux = {1'b0, 5'h00, s.irq_status};
        end else if (reg_hit(addr, atmd_pkg::IDX_IRQ_CLEAR)) begin
            read_mux = {1'b0, 8'h00};
        end else if (reg_hit(addr, atmd_pkg::IDX_IRQ_ENABLE)) begin
            read_mux = {1'b0, 5'h00, s.irq_enable};
        end
    endfunction : read_mux

    // ========================================================================
    // State and bus decode.
    // ========================================================================
    atmd_pkg::atmd_state_s st_reg;
    atmd_pkg::atmd_state_s st_next;

    logic       access;
    logic       wr_en;
    logic       wr_target;
    logic       wr_mod;
    logic       wr_trim;
    logic       wr_mask;
    logic       wr_cmd;
    logic       wr_clear;
    logic       wr_enable;
    logic       set_default;
    logic [2:0] irq_set;
    logic [8:0] rd_word;

    // A transfer completes on the access cycle in which pready is high.
    assign access    = psel & penable & st_reg.pready;
    assign wr_en     = access & pwrite;
    assign wr_target = wr_en & reg_hit(paddr, atmd_pkg::IDX_PHASE_TARGET);
    assign wr_mod    = wr_en & reg_hit(paddr, atmd_pkg::IDX_MOD_CTRL);
    assign wr_trim   = wr_en & reg_hit(paddr, atmd_pkg::IDX_TRIM_CTRL);
    assign wr_mask   = wr_en & reg_hit(paddr, atmd_pkg::IDX_SEG_MASK);
    assign wr_cmd    = wr_en & reg_hit(paddr, atmd_pkg::IDX_COMMAND);
    assign wr_clear  = wr_en & reg_hit(paddr, atmd_pkg::IDX_IRQ_CLEAR);
    assign wr_enable = wr_en & reg_hit(paddr, atmd_pkg::IDX_IRQ_ENABLE);
    assign set_default = wr_cmd & pwdata[atmd_pkg::CMD_SET_DEFAULT];
    assign rd_word   = read_mux(paddr, st_reg);

    // Engine events that raise sticky interrupt status bits.
    assign irq_set[atmd_pkg::IRQ_ANT_DONE] = ant_cal_res.done;
    assign irq_set[atmd_pkg::IRQ_ANT_ERR]  = ant_cal_res.done & ant_cal_res.err;
    assign irq_set[atmd_pkg::IRQ_MOD_DONE] = mod_cal_res.done;

    // ========================================================================
    // Next-state logic.
    // ========================================================================
    // Computes every register, the bus answer and the registered outputs.
    always_comb begin
        st_next = st_reg;
        st_next.ant_start = 1'b0;
        st_next.mod_start = 1'b0;
        // Ready is raised for the access cycle that follows each setup cycle.
        st_next.pready = psel & ~penable;
        if (psel & ~penable) begin
            st_next.prdata  = {24'h000000, rd_word[7:0]};
            st_next.pslverr = rd_word[8];
        end

        // The antenna engine result lands in the view register.
        if (ant_cal_res.done) begin
            st_next.result_view = {ant_cal_res.trim,
                                   ant_cal_res.err,
                                   3'h0};
        end
        // Depth calibration only retunes the code while auto level is chosen.
        if (mod_cal_res.done && !st_reg.mod_ctrl[atmd_pkg::MOD_SEL_BIT]) begin
            st_next.mod_ctrl[atmd_pkg::DEPTH_MSB:atmd_pkg::DEPTH_LSB] =
                mod_cal_res.code;
        end

        // Software writes; unused bits are masked off.
        if (wr_target) begin
            st_next.phase_target = pwdata[7:0];
        end
        if (wr_mod) begin
            st_next.mod_ctrl = pwdata[7:0] & atmd_pkg::MOD_CTRL_WMASK;
        end
        if (wr_trim) begin
            st_next.trim_ctrl = pwdata[7:0] & atmd_pkg::TRIM_CTRL_WMASK;
        end
        if (wr_mask) begin
            st_next.seg_mask = pwdata[7:0];
        end
        if (wr_enable) begin
            st_next.irq_enable = pwdata[2:0];
        end
        if (wr_cmd) begin
            st_next.ant_start = pwdata[atmd_pkg::CMD_CAL_ANT];
            st_next.mod_start = pwdata[atmd_pkg::CMD_CAL_MOD];
        end

        // Status: a new event wins over a clear in the same cycle.
        st_next.irq_status = (st_reg.irq_status & ~(wr_clear ? pwdata[2:0]
                                                             : 3'h0))
                             | irq_set;

        // Set-default returns target, view, control, trim and mask registers to reset values; the interrupt enables are kept.
        if (set_default) begin
            st_next.phase_target = atmd_pkg::PHASE_TARGET_RST;
            st_next.mod_ctrl     = atmd_pkg::MOD_CTRL_RST;
            st_next.result_view  = atmd_pkg::RESULT_VIEW_RST;
            st_next.trim_ctrl    = atmd_pkg::TRIM_CTRL_RST;
            st_next.seg_mask     = atmd_pkg::SEG_MASK_RST;
        end

        // Tank switch source follows the trim select.
        if (st_next.trim_ctrl[atmd_pkg::TRIM_SEL_BIT]) begin
            st_next.trim_out = st_next.trim_ctrl[atmd_pkg::TRIM_MAN_MSB:
                                                 atmd_pkg::TRIM_MAN_LSB];
        end else begin
            st_next.trim_out = st_next.result_view[atmd_pkg::RES_TRIM_MSB:
                                                   atmd_pkg::RES_TRIM_LSB];
        end
        // Segment mask applies only while the manual level source is chosen.
        if (st_next.mod_ctrl[atmd_pkg::MOD_SEL_BIT]) begin
            st_next.seg_disable = st_next.seg_mask;
        end else begin
            st_next.seg_disable = 8'h00;
        end
        st_next.irq = |(st_next.irq_status & st_next.irq_enable);
    end

    // ========================================================================
    // State register.
    // ========================================================================
    // Registers the whole state; power-up loads the defaults.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= atmd_pkg::ATMD_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state register.
    assign prdata                  = st_reg.prdata;
    assign pready                  = st_reg.pready;
    assign pslverr                 = st_reg.pslverr;
    assign ant_cal_start           = st_reg.ant_start;
    assign mod_cal_start           = st_reg.mod_start;
    assign phase_target            = st_reg.phase_target;
    assign tank_switch_pin_set_one = st_reg.trim_out;
    assign tank_switch_pin_set_two = st_reg.trim_out;
    assign mod_level_source_sel    = st_reg.mod_ctrl[atmd_pkg::MOD_SEL_BIT];
    assign depth_code = st_reg.mod_ctrl[atmd_pkg::DEPTH_MSB:atmd_pkg::DEPTH_LSB];
    assign am_segment_disable      = st_reg.seg_disable;
    assign irq                     = st_reg.irq;

    // ========================================================================
    // Assertions and covers.
    // ========================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A target write lands on the next edge.
    AST_TARGET_WRITE: assert property (
        wr_target |=> phase_target == $past(pwdata[7:0]))
        else $error("phase target did not take the written value");

    // Set-default restores target and clears modulation control.
    AST_SET_DEFAULT: assert property (
        set_default |=> phase_target == 8'h80 && st_reg.mod_ctrl == 8'h00)
        else $error("set-default did not restore target and control");

    // The engine trim result appears in view bits 7 to 4.
    AST_RESULT_CAPTURE: assert property (
        ant_cal_res.done && !set_default
        |=> st_reg.result_view[7:4] == $past(ant_cal_res.trim))
        else $error("trim result not captured in view register");

    // Automatic trim source drives both pin sets from the view bits.
    AST_TRIM_AUTO: assert property (
        !st_reg.trim_ctrl[7] |-> tank_switch_pin_set_one ==
        st_reg.result_view[7:4] && tank_switch_pin_set_two ==
        st_reg.result_view[7:4])
        else $error("tank switches do not follow the result");

    // A failed calibration sets the error flag.
    AST_ERR_FLAG: assert property (
        ant_cal_res.done && ant_cal_res.err && !set_default
        |=> st_reg.result_view[3] ##1 st_reg.result_view[3] ||
        $past(ant_cal_res.done) || $past(set_default))
        else $error("calibration error flag not set or lost");

    // Set-default clears the whole view register.
    AST_VIEW_CLEAR: assert property (
        set_default |=> st_reg.result_view == 8'h00)
        else $error("view register not cleared by set-default");

    // With auto level source no segment is disabled by the mask.
    AST_AUTO_LEVEL: assert property (
        !mod_level_source_sel |-> am_segment_disable == 8'h00)
        else $error("segments disabled while auto level chosen");

    // Depth calibration updates the code only under auto level source.
    AST_DEPTH_UPDATE: assert property (
        mod_cal_res.done && !mod_level_source_sel && !wr_mod && !set_default
        |=> depth_code == $past(mod_cal_res.code))
        else $error("depth code not updated by calibration");

    // Under manual level source the code is left alone by calibration.
    AST_DEPTH_HOLD: assert property (
        mod_cal_res.done && mod_level_source_sel && !wr_mod && !set_default
        |=> $stable(depth_code))
        else $error("depth code changed under manual level source");

    // Manual trim source drives the pins from the written trim bits.
    AST_TRIM_MANUAL: assert property (
        st_reg.trim_ctrl[7] |-> tank_switch_pin_set_one ==
        st_reg.trim_ctrl[6:3])
        else $error("tank switches do not follow manual trim");

    // Manual level source applies the segment mask.
    AST_SEG_MASK: assert property (
        mod_level_source_sel |-> am_segment_disable == st_reg.seg_mask)
        else $error("segment disable does not match mask");

    // Unused bits stay zero.
    AST_UNUSED_ZERO: assert property (
        st_reg.mod_ctrl[0] == 1'b0 && st_reg.result_view[2:0] == 3'h0 &&
        st_reg.trim_ctrl[2:0] == 3'h0)
        else $error("unused register bits are not zero");

    // Both pin sets carry one drive.
    AST_PINS_MATCH: assert property (
        tank_switch_pin_set_one == tank_switch_pin_set_two)
        else $error("pin sets differ");

    // Auto source pins follow a new result.
    AST_PINS_FOLLOW: assert property (
        ant_cal_res.done && !st_reg.trim_ctrl[7] && !wr_trim && !set_default
        |=> tank_switch_pin_set_one == $past(ant_cal_res.trim))
        else $error("pins miss new result");

    // Manual source pins ignore results.
    AST_TRIM_KEEP: assert property (
        st_reg.trim_ctrl[7] && !wr_trim && !set_default
        |=> $stable(tank_switch_pin_set_one))
        else $error("manual pins moved");

    // A clean result clears the error flag.
    AST_ERR_CLEAR: assert property (
        ant_cal_res.done && !ant_cal_res.err && !set_default
        |=> !st_reg.result_view[3])
        else $error("error flag not cleared");

    // An error result sets its status bit.
    AST_ERR_STATUS: assert property (
        ant_cal_res.done && ant_cal_res.err |=> st_reg.irq_status[1])
        else $error("error status not set");

    // The view changes only on a result or set-default.
    AST_VIEW_HOLD: assert property (
        !ant_cal_res.done && !set_default |=> $stable(st_reg.result_view))
        else $error("view changed without a result");

    // Control writes drop the unused bit.
    AST_MOD_MASK: assert property (
        wr_mod |=> st_reg.mod_ctrl == ($past(pwdata[7:0]) & 8'hFE))
        else $error("control write not masked");

    // The target moves only on a write or set-default.
    AST_TARGET_HOLD: assert property (
        !wr_target && !set_default |=> $stable(phase_target))
        else $error("target changed unasked");

    // The code moves only on calibration, write or set-default.
    AST_CODE_KEEP: assert property (
        !mod_cal_res.done && !wr_mod && !set_default |=> $stable(depth_code))
        else $error("depth code changed unasked");

    // The mask holds under the manual level source.
    AST_SEG_HOLD: assert property (
        mod_level_source_sel && !wr_mask && !wr_mod && !set_default
        |=> $stable(am_segment_disable))
        else $error("segment disable moved");

    COV_CAL_ERROR:  cover property (ant_cal_res.done && ant_cal_res.err);
    COV_MANUAL_SEG: cover property (wr_mod ##1 mod_level_source_sel);
    COV_DEFAULT:    cover property (set_default ##1 phase_target == 8'h80);
    COV_IRQ:        cover property (irq);
    COV_DEPTH_CAL:  cover property (mod_cal_res.done && !mod_level_source_sel);

endmodule : atmd_regs

/* tb_antenna_tune_mod_depth_regs.sv */
// Self-checking testbench for the antenna tuning and depth register bank.
`timescale 1ns/100ps

module tb_antenna_tune_mod_depth_regs;

    // ========================================================================
    // Clock, reset, stimulus and observed signals.
    // ========================================================================
    logic                    pclk;
    logic                    presetn;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [7:0]              paddr;
    logic [31:0]             pwdata;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    atmd_pkg::atmd_ant_res_s ant_res;
    atmd_pkg::atmd_mod_res_s mod_res;
    logic                    ant_cal_start;
    logic                    mod_cal_start;
    logic [7:0]              phase_target;
    logic [3:0]              pins_one;
    logic [3:0]              pins_two;
    logic                    mod_sel;
    logic [5:0]              depth_code;
    logic [7:0]              seg_disable;
    logic                    irq;
    int                      n_mismatch;
    int                      compares;
    int                      cycles;
    logic [31:0]             rd;
    logic                    er;

    atmd_regs uut (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .psel                    (psel),
        .penable                 (penable),
        .pwrite                  (pwrite),
        .paddr                   (paddr),
        .pwdata                  (pwdata),
        .prdata                  (prdata),
        .pready                  (pready),
        .pslverr                 (pslverr),
        .ant_cal_res             (ant_res),
        .mod_cal_res             (mod_res),
        .ant_cal_start           (ant_cal_start),
        .mod_cal_start           (mod_cal_start),
        .phase_target            (phase_target),
        .tank_switch_pin_set_one (pins_one),
        .tank_switch_pin_set_two (pins_two),
        .mod_level_source_sel    (mod_sel),
        .depth_code              (depth_code),
        .am_segment_disable      (seg_disable),
        .irq                     (irq)
    );

    // Free-running 200 MHz clock.
    always #2.5 pclk = ~pclk;

    // Cycle counter that cuts a hang short.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end

    // ========================================================================
    // Shared tasks.
    // ========================================================================
    // Compares a seen value with the expected one and counts the result.
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp,
                       input string msg);
        compares = compares + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask : chk

    // One APB transfer to a register index; waits for pready.
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= idx << 2;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Lets one edge pass so registered outputs have settled.
    task automatic settle();
        @(posedge pclk);
        #1;
    endtask : settle

    // Reads a register and compares its low byte and the error flag.
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                          input string msg);
        apb(1'b0, idx, 32'h0);
        chk({er, rd}, {1'b0, 24'h0, exp}, msg);
    endtask : rd_chk

    // Presents one antenna engine result for one cycle.
    task automatic ant_event(input logic err, input logic [3:0] trim);
        @(posedge pclk);
        ant_res <= {1'b1, err, trim};
        @(posedge pclk);
        ant_res <= {1'b0, 1'b0, 4'h0};
        settle();
    endtask : ant_event

    // Presents one depth engine result for one cycle.
    task automatic mod_event(input logic [5:0] code);
        @(posedge pclk);
        mod_res <= {1'b1, code};
        @(posedge pclk);
        mod_res <= {1'b0, 6'h00};
        settle();
    endtask : mod_event

    // ========================================================================
    // Scenarios.
    // ========================================================================
    // Reset values of the registers and outputs.
    task automatic t_reset();
        rd_chk(atmd_pkg::IDX_PHASE_TARGET, 8'h80, "target rst");
        rd_chk(atmd_pkg::IDX_RESULT_VIEW, 8'h00, "view rst");
        rd_chk(atmd_pkg::IDX_MOD_CTRL, 8'h00, "mod rst");
        chk({irq, pins_one, depth_code}, 32'h0, "pins rst");
    endtask : t_reset

    // Target register is read/write and drives its port.
    task automatic t_target();
        apb(1'b1, atmd_pkg::IDX_PHASE_TARGET, 32'h5A);
        settle();
        chk(phase_target, 32'h5A, "target port");
        rd_chk(atmd_pkg::IDX_PHASE_TARGET, 8'h5A, "target rd");
        apb(1'b0, 8'h3F, 32'h0);
        chk({er, rd}, {1'b1, 32'h0}, "unmapped");
    endtask : t_target

    // Calibration result, error flag and trim switch sources.
    task automatic t_antenna();
        ant_event(1'b1, 4'hA);
        rd_chk(atmd_pkg::IDX_RESULT_VIEW, 8'hA8, "view err");
        chk({pins_one, pins_two}, 32'hAA, "pins auto");
        apb(1'b1, atmd_pkg::IDX_RESULT_VIEW, 32'hFF);
        rd_chk(atmd_pkg::IDX_RESULT_VIEW, 8'hA8, "view ro");
        ant_event(1'b0, 4'h3);
        rd_chk(atmd_pkg::IDX_RESULT_VIEW, 8'h30, "view trim");
        apb(1'b1, atmd_pkg::IDX_TRIM_CTRL, 32'hAF);
        settle();
        chk({pins_one, pins_two}, 32'h55, "pins manual");
        apb(1'b1, atmd_pkg::IDX_TRIM_CTRL, 32'h00);
        settle();
        chk({pins_one, pins_two}, 32'h33, "pins back");
    endtask : t_antenna

    // Level source select, depth code and segment mask.
    task automatic t_mod();
        apb(1'b1, atmd_pkg::IDX_MOD_CTRL, 32'hFF);
        rd_chk(atmd_pkg::IDX_MOD_CTRL, 8'hFE, "mod unused");
        apb(1'b1, atmd_pkg::IDX_SEG_MASK, 32'hC3);
        settle();
        chk({mod_sel, seg_disable}, {1'b1, 8'hC3}, "seg on");
        chk(depth_code, 32'h3F, "depth hold");
        mod_event(6'h15);
        rd_chk(atmd_pkg::IDX_MOD_CTRL, 8'hFE, "mod ignored");
        apb(1'b1, atmd_pkg::IDX_MOD_CTRL, 32'h00);
        settle();
        chk({mod_sel, seg_disable}, 32'h0, "seg off");
        mod_event(6'h2D);
        chk(depth_code, 32'h2D, "depth auto");
        rd_chk(atmd_pkg::IDX_MOD_CTRL, 8'h5A, "mod code");
    endtask : t_mod

    // Start pulses and the interrupt raise, mask and clear.
    task automatic t_irq();
        logic [1:0] seen;
        for (int b = 1; b <= 2; b++) begin
            seen = 2'b00;
            apb(1'b1, atmd_pkg::IDX_COMMAND, 32'h1 << b);
            repeat (3) begin
                #1;
                seen = seen | {mod_cal_start, ant_cal_start};
                @(posedge pclk);
            end
            chk(seen, b, "start pulse");
        end
        apb(1'b1, atmd_pkg::IDX_IRQ_CLEAR, 32'h7);
        apb(1'b1, atmd_pkg::IDX_IRQ_ENABLE, 32'h3);
        ant_event(1'b1, 4'h6);
        rd_chk(atmd_pkg::IDX_IRQ_STATUS, 8'h03, "status");
        chk(irq, 1'b1, "irq high");
        apb(1'b1, atmd_pkg::IDX_IRQ_CLEAR, 32'h3);
        settle();
        chk(irq, 1'b0, "irq clear");
        apb(1'b1, atmd_pkg::IDX_IRQ_ENABLE, 32'h0);
        ant_event(1'b0, 4'h6);
        chk(irq, 1'b0, "irq masked");
        rd_chk(atmd_pkg::IDX_IRQ_STATUS, 8'h01, "status masked");
    endtask : t_irq

    // Set-default command and a mid-run reset restore the defaults.
    task automatic t_default();
        apb(1'b1, atmd_pkg::IDX_MOD_CTRL, 32'h82);
        apb(1'b1, atmd_pkg::IDX_COMMAND, 32'h1);
        settle();
        rd_chk(atmd_pkg::IDX_PHASE_TARGET, 8'h80, "target dflt");
        rd_chk(atmd_pkg::IDX_RESULT_VIEW, 8'h00, "view dflt");
        rd_chk(atmd_pkg::IDX_MOD_CTRL, 8'h00, "mod dflt");
        chk({phase_target, mod_sel}, {8'h80, 1'b0}, "ports dflt");
        apb(1'b1, atmd_pkg::IDX_PHASE_TARGET, 32'h33);
        apb(1'b1, atmd_pkg::IDX_MOD_CTRL, 32'h82);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(atmd_pkg::IDX_PHASE_TARGET, 8'h80, "target rerst");
        chk({mod_sel, depth_code}, 32'h0, "mod rerst");
    endtask : t_default

    // Prints the verdict and ends the run.
    task automatic tally_and_finish();
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // ========================================================================
    // Main sequence.
    // ========================================================================
    initial begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        ant_res    = '0;
        mod_res    = '0;
        n_mismatch = 0;
        compares   = 0;
        cycles     = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_target();
        t_antenna();
        t_mod();
        t_irq();
        t_default();
        tally_and_finish();
    end

endmodule : tb_antenna_tune_mod_depth_regs
